// ==== pixel_memory_write_consts.svh ====
/*
 Constants of the pixel memory write path: operation codes, host bus width
 codes, pointer stepping and reset values.
 Assumes inclusion by bare name from the design module, the checker and the bench.
*/
`ifndef PIXEL_MEMORY_WRITE_CONSTS_SVH
`define PIXEL_MEMORY_WRITE_CONSTS_SVH

// Combine operation codes
`define OP_REPLACE      3'h0
`define OP_OR           3'h1
`define OP_AND          3'h2
`define OP_XOR          3'h3
`define OP_STORED_MATCH 3'h4
`define OP_STORED_MISS  3'h5
`define OP_HOST_MATCH   3'h6
`define OP_HOST_MISS    3'h7

// Host bus width codes
`define BUS_W18         2'h0
`define BUS_W16         2'h1
`define BUS_W9          2'h2
`define BUS_W8          2'h3

// Vertical step adds one raster row, the pointer high byte
`define ROW_STEP        16'h0100
`define COL_STEP        16'h0001

// Field positions within the pointer
`define COL_LSB         0
`define ROW_LSB         8

// Reset values
`define PTR_RESET       16'h0000
`define WORD_RESET      16'h0000

`endif

// ==== pixel_memory_write_pkg.sv ====
/*
 Types shared by the pixel memory write path.
 Assumes pixel_memory_write_consts.svh is on the include path.
*/
package pixel_memory_write_pkg;
    typedef enum logic [1:0]
    {
        st_idle,
        st_read,
        st_latch,
        st_write
    } engine_state_t;
endpackage

// ==== pixel_memory_window_graphics_write.sv ====
/*
 Write path into the pixel memory: two-entry input buffer, window-confined
 pointer stepping and per-word graphics operations (mask, logic, compare).
 Assumes a synchronous pixel memory on clk: a read pulse on mem_re returns
 mem_rdata in the next cycle; all control inputs come from logic on clk.
*/
// Notes on behaviour
// - Keep consecutive writes inside the 8-bit window bounds.
// - Horizontal: step pointer by one, continue one row below at edge, or at the top row after the last row.
// - Vertical: add 256; past bottom return to top, column +1 or -1 per step sign.
// - Code 000 replaces; direction bit picks horizontal or vertical.
// - Codes 110/111 compare host word with match value as a word.
// - Codes 001-011 combine stored and host words; 001 is OR.
// - Stored word goes to an internal latch, never to the host.
// - Codes 100/101 replace conditionally, stepping per direction bit.
// - Mask bit 0 writes the operation result bit, 1 keeps the stored bit.
// - 18-bit and 9-bit hosts get only plain replacement modes.
// - Protect mask applies only on 8-bit and 16-bit host buses.
// - Codes 100/101 compare stored word with match value per byte.
`include "pixel_memory_write_consts.svh"

module pixel_memory_window_graphics_write
#(
    parameter int DATA_W = 16
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [7:0]        win_col_first,
    input  wire logic [7:0]        win_col_last,
    input  wire logic [7:0]        win_row_first,
    input  wire logic [7:0]        win_row_last,
    input  wire logic              write_direction_select,
    input  wire logic              step_sign,
    input  wire logic [2:0]        combine_op_code,
    input  wire logic [DATA_W-1:0] bit_protect_mask,
    input  wire logic [DATA_W-1:0] match_value,
    input  wire logic [1:0]        bus_width_code,
    input  wire logic              burst_write_enable,
    input  wire logic              burst_direction_flag,
    input  wire logic              pointer_load,
    input  wire logic [15:0]       memory_pointer,
    input  wire logic              in_valid,
    input  wire logic [DATA_W-1:0] in_data,
    output logic                   in_ready,
    output logic [15:0]            pixel_pointer,
    output logic [15:0]            mem_addr,
    output logic [DATA_W-1:0]      mem_wdata,
    output logic                   mem_we,
    output logic                   mem_re,
    input  wire logic [DATA_W-1:0] mem_rdata,
    output logic                   busy
);

    localparam int NBYTES = DATA_W / 8;

    generate
        if (DATA_W != 16)
        begin : g_bad_width
            $error("DATA_W must be 16");
        end
    endgenerate

    // Two-entry input buffer
    logic [DATA_W-1:0] buf_word_reg [0:1];
    logic [DATA_W-1:0] buf_word_next [0:1];
    logic [1:0]        buf_count_reg;
    logic [1:0]        buf_count_next;
    logic              in_ready_reg;
    logic              in_ready_next;
    logic              buf_pop;
    logic              buf_push;

    // Write engine
    pixel_memory_write_pkg::engine_state_t state_reg;
    pixel_memory_write_pkg::engine_state_t state_next;
    logic [15:0]       ptr_reg;
    logic [15:0]       ptr_next;
    logic [DATA_W-1:0] host_word_reg;
    logic [DATA_W-1:0] host_word_next;
    logic [DATA_W-1:0] read_latch_reg;
    logic [DATA_W-1:0] read_latch_next;
    logic [15:0]       mem_addr_reg;
    logic [15:0]       mem_addr_next;
    logic [DATA_W-1:0] mem_wdata_reg;
    logic [DATA_W-1:0] mem_wdata_next;
    logic              mem_we_reg;
    logic              mem_we_next;
    logic              mem_re_reg;
    logic              mem_re_next;

    logic              narrow_ok;
    logic [2:0]        eff_op;
    logic [DATA_W-1:0] eff_mask;
    logic              need_read;
    logic [DATA_W-1:0] combined;
    logic [DATA_W-1:0] byte_keep;
    logic              word_write;
    logic [DATA_W-1:0] merged;
    logic [15:0]       stepped;
    logic [7:0]        cur_col;
    logic [7:0]        cur_row;

    assign narrow_ok = (bus_width_code == `BUS_W16) ||
                       (bus_width_code == `BUS_W8);
    assign eff_op    = narrow_ok ? combine_op_code : `OP_REPLACE;
    assign eff_mask  = narrow_ok ? bit_protect_mask : '0;
    assign need_read = (eff_op != `OP_REPLACE) &&
                       (eff_op != `OP_HOST_MATCH) &&
                       (eff_op != `OP_HOST_MISS);

    assign cur_col = ptr_reg[`COL_LSB +: 8];
    assign cur_row = ptr_reg[`ROW_LSB +: 8];

    // Per-byte keep mask for the stored-data compare modes
    genvar gb;
    generate
        for (gb = 0; gb < NBYTES; gb++)
        begin : g_byte_cmp
            logic same;
            assign same = read_latch_reg[gb*8 +: 8] == match_value[gb*8 +: 8];
            assign byte_keep[gb*8 +: 8] =
                ((eff_op == `OP_STORED_MATCH) && !same) ||
                ((eff_op == `OP_STORED_MISS) && same) ? 8'hff : 8'h00;
        end
    endgenerate

    // Operation result before masking
    always_comb
    begin
        combined   = host_word_reg;
        word_write = 1'b1;
        case (eff_op)
            `OP_REPLACE:
                combined = host_word_reg;
            `OP_OR:
                combined = read_latch_reg | host_word_reg;
            `OP_AND:
                combined = read_latch_reg & host_word_reg;
            `OP_XOR:
                combined = read_latch_reg ^ host_word_reg;
            `OP_STORED_MATCH, `OP_STORED_MISS:
                combined = (host_word_reg & ~byte_keep) |
                           (read_latch_reg & byte_keep);
            `OP_HOST_MATCH:
                word_write = (host_word_reg == match_value);
            `OP_HOST_MISS:
                word_write = (host_word_reg != match_value);
            default:
                combined = host_word_reg;
        endcase
    end

    // Protected bits keep the stored value
    assign merged = combined & ~eff_mask | read_latch_reg & eff_mask;

    // Next pointer, wrapping at the window edges
    always_comb
    begin
        stepped = ptr_reg;
        if (!write_direction_select)
        begin
            if (step_sign)
            begin
                if (cur_col == win_col_last)
                    stepped = {cur_row == win_row_last ? win_row_first
                               : 8'(cur_row + 8'h01), win_col_first};
                else
                    stepped = ptr_reg + `COL_STEP;
            end
            else
            begin
                if (cur_col == win_col_first)
                    stepped = {cur_row == win_row_last ? win_row_first
                               : 8'(cur_row + 8'h01), win_col_last};
                else
                    stepped = ptr_reg - `COL_STEP;
            end
        end
        else
        begin
            if (cur_row == win_row_last)
            begin
                if (step_sign)
                    stepped = {win_row_first, cur_col == win_col_last
                               ? win_col_first : 8'(cur_col + 8'h01)};
                else
                    stepped = {win_row_first, cur_col == win_col_first
                               ? win_col_last : 8'(cur_col - 8'h01)};
            end
            else
                stepped = ptr_reg + `ROW_STEP;
        end
    end

    // Engine sequencing
    always_comb
    begin
        state_next      = state_reg;
        ptr_next        = ptr_reg;
        host_word_next  = host_word_reg;
        read_latch_next = read_latch_reg;
        mem_addr_next   = mem_addr_reg;
        mem_wdata_next  = mem_wdata_reg;
        mem_we_next     = 1'b0;
        mem_re_next     = 1'b0;
        buf_pop         = 1'b0;
        case (state_reg)
            pixel_memory_write_pkg::st_idle:
            begin
                if (pointer_load)
                    ptr_next = memory_pointer;
                else if (buf_count_reg != 2'h0)
                begin
                    buf_pop        = 1'b1;
                    host_word_next = buf_word_reg[0];
                    mem_addr_next  = ptr_reg;
                    if (need_read || (eff_mask != '0))
                    begin
                        mem_re_next = 1'b1;
                        state_next  = pixel_memory_write_pkg::st_read;
                    end
                    else
                    begin
                        read_latch_next = `WORD_RESET;
                        state_next      = pixel_memory_write_pkg::st_write;
                    end
                end
            end
            pixel_memory_write_pkg::st_read:
                state_next = pixel_memory_write_pkg::st_latch;
            pixel_memory_write_pkg::st_latch:
            begin
                read_latch_next = mem_rdata;
                state_next      = pixel_memory_write_pkg::st_write;
            end
            pixel_memory_write_pkg::st_write:
            begin
                mem_wdata_next = merged;
                mem_we_next    = word_write;
                ptr_next       = stepped;
                state_next     = pixel_memory_write_pkg::st_idle;
            end
            default:
                state_next = pixel_memory_write_pkg::st_idle;
        endcase
    end

    // Buffer bookkeeping; ready is registered so it leads the count by one
    assign buf_push = in_valid && in_ready_reg;

    always_comb
    begin
        buf_word_next[0] = buf_word_reg[0];
        buf_word_next[1] = buf_word_reg[1];
        buf_count_next   = buf_count_reg;
        if (buf_pop)
        begin
            buf_word_next[0] = buf_word_reg[1];
            buf_count_next   = 2'(buf_count_next - 2'h1);
        end
        if (buf_push)
        begin
            buf_word_next[buf_count_next[0]] = in_data;
            buf_count_next = 2'(buf_count_next + 2'h1);
        end
        in_ready_next = (buf_count_next < 2'h2) &&
                        !(buf_push && buf_count_next == 2'h1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_word_reg[0] <= `WORD_RESET;
            buf_word_reg[1] <= `WORD_RESET;
            buf_count_reg   <= 2'h0;
            in_ready_reg    <= 1'b0;
        end
        else if (clk_en)
        begin
            buf_word_reg[0] <= buf_word_next[0];
            buf_word_reg[1] <= buf_word_next[1];
            buf_count_reg   <= buf_count_next;
            in_ready_reg    <= in_ready_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg      <= pixel_memory_write_pkg::st_idle;
            ptr_reg        <= `PTR_RESET;
            host_word_reg  <= `WORD_RESET;
            read_latch_reg <= `WORD_RESET;
            mem_addr_reg   <= `PTR_RESET;
            mem_wdata_reg  <= `WORD_RESET;
            mem_we_reg     <= 1'b0;
            mem_re_reg     <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg      <= state_next;
            ptr_reg        <= ptr_next;
            host_word_reg  <= host_word_next;
            read_latch_reg <= read_latch_next;
            mem_addr_reg   <= mem_addr_next;
            mem_wdata_reg  <= mem_wdata_next;
            mem_we_reg     <= mem_we_next;
            mem_re_reg     <= mem_re_next;
        end
    end

    // Busy also covers the write pulse, so memory is settled when it drops
    logic busy_reg;
    logic busy_next;

    assign busy_next = (state_next != pixel_memory_write_pkg::st_idle) ||
                       (buf_count_next != 2'h0) || mem_we_next;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else if (clk_en)
            busy_reg <= busy_next;
    end

    assign in_ready      = in_ready_reg;
    assign pixel_pointer = ptr_reg;
    assign mem_addr      = mem_addr_reg;
    assign mem_wdata     = mem_wdata_reg;
    assign mem_we        = mem_we_reg;
    assign mem_re        = mem_re_reg;
    assign busy          = busy_reg;

endmodule

// ==== pixel_memory_model.sv ====
/*
 Behavioural synchronous pixel memory facing the write path.
 Assumes one clock; read data is valid only in the cycle after a read pulse.
*/
module pixel_memory_model
(
    input  wire logic        clk,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:65535];
    initial mem_rdata = 16'h5a5a;
    // Outside the read slot the data lines toggle, never hold stale data
    always @(posedge clk)
    begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
        if (mem_re)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// ==== pixel_memory_write_checker_assertions.sv ====
/*
 Port-level checker of the pixel memory write path, bound to its top module.
 Assumes one clock and a host that keeps the pointer inside the window.
*/
`include "pixel_memory_write_consts.svh"
module pixel_memory_write_checker
#(
    parameter int DATA_W = 16
)
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [7:0]        win_col_first,
    input wire logic [7:0]        win_col_last,
    input wire logic [7:0]        win_row_first,
    input wire logic [7:0]        win_row_last,
    input wire logic              write_direction_select,
    input wire logic              step_sign,
    input wire logic [2:0]        combine_op_code,
    input wire logic [DATA_W-1:0] bit_protect_mask,
    input wire logic [DATA_W-1:0] match_value,
    input wire logic [1:0]        bus_width_code,
    input wire logic [15:0]       pixel_pointer,
    input wire logic [15:0]       mem_addr,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic              mem_we,
    input wire logic              mem_re,
    input wire logic [DATA_W-1:0] mem_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0]        col;
    logic [7:0]        row;
    logic              hz;
    logic              vt;
    logic              wide;
    logic              re_d_reg;
    logic [DATA_W-1:0] rd_reg;
    assign col = mem_addr[7:0];
    assign row = mem_addr[15:8];
    assign hz = mem_we && !write_direction_select;
    assign vt = mem_we && write_direction_select;
    assign wide = bus_width_code == `BUS_W16 || bus_width_code == `BUS_W8;
    // Stored word as it stood in the slot after each read pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            re_d_reg <= 1'b0;
        else
            re_d_reg <= mem_re;
    end
    always_ff @(posedge clk)
    begin
        if (re_d_reg)
            rd_reg <= mem_rdata;
    end
    a_write_inside: assert property (
        mem_we |-> col >= win_col_first && col <= win_col_last
        && row >= win_row_first && row <= win_row_last)
        else $error("write outside window");
    a_hstep_up: assert property (
        hz && step_sign && col != win_col_last
        |-> pixel_pointer == mem_addr + 16'h0001)
        else $error("bad upward step");
    a_hstep_down: assert property (
        hz && !step_sign && col != win_col_first
        |-> pixel_pointer == mem_addr - 16'h0001)
        else $error("bad downward step");
    a_hwrap_edge: assert property (
        hz && step_sign && col == win_col_last |-> pixel_pointer ==
        {(row == win_row_last) ? win_row_first : row + 8'h01, win_col_first})
        else $error("bad row wrap");
    a_vstep_row: assert property (
        vt && row != win_row_last |-> pixel_pointer == mem_addr + 16'h0100)
        else $error("bad vertical step");
    a_vwrap_top: assert property (
        vt && step_sign && row == win_row_last && col != win_col_last
        |-> pixel_pointer == {win_row_first, col + 8'h01})
        else $error("bad column wrap");
    a_read_pulse: assert property (
        mem_re |=> !mem_re ##1 !mem_re)
        else $error("read pulse too long");
    a_narrow_noread: assert property (
        mem_re |-> wide)
        else $error("read on narrow bus");
    a_word_match: assert property (
        mem_we && wide && combine_op_code == `OP_HOST_MATCH
        && bit_protect_mask == '0 |-> mem_wdata == match_value)
        else $error("write without word match");
    a_mask_keep: assert property (
        mem_we && wide |-> ((mem_wdata ^ rd_reg) & bit_protect_mask) == '0)
        else $error("protected bit changed");
    cover property (hz && col == win_col_last);
    cover property (vt && row == win_row_last);
    cover property (mem_we && combine_op_code == `OP_STORED_MISS);
endmodule
bind pixel_memory_window_graphics_write pixel_memory_write_checker #(.DATA_W(DATA_W)) chk_inst
(
    .clk, .rst_n, .win_col_first, .win_col_last, .win_row_first,
    .win_row_last, .write_direction_select, .step_sign, .combine_op_code,
    .bit_protect_mask, .match_value, .bus_width_code, .pixel_pointer,
    .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata
);

// ==== tb.sv ====
/*
 Self-checking bench of the pixel memory write path.
 Assumes the memory model answers reads one cycle after the read pulse.
*/
`include "pixel_memory_write_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_n = 1'b0, pointer_load = 1'b0;
    logic        in_valid = 1'b0, write_direction_select = 1'b0;
    logic        step_sign = 1'b0, stalled = 1'b0;
    logic [7:0]  win_col_first = 8'h0a, win_col_last = 8'h0c;
    logic [7:0]  win_row_first = 8'h14, win_row_last = 8'h15;
    logic [2:0]  combine_op_code = 3'h0;
    logic [1:0]  bus_width_code = `BUS_W16;
    logic [15:0] bit_protect_mask = 16'h0000, match_value = 16'h2860;
    logic [15:0] memory_pointer = 16'h0000, in_data = 16'h0000;
    logic [15:0] pixel_pointer, mem_addr, mem_wdata, mem_rdata;
    logic        in_ready, mem_we, mem_re, busy;
    int          n_errors = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    pixel_memory_window_graphics_write pixel_memory_window_graphics_write_inst
    (
        .clk, .rst_n, .clk_en(1'b1), .win_col_first, .win_col_last,
        .win_row_first, .win_row_last, .write_direction_select, .step_sign,
        .combine_op_code, .bit_protect_mask, .match_value, .bus_width_code,
        .burst_write_enable(1'b0), .burst_direction_flag(1'b0),
        .pointer_load, .memory_pointer, .in_valid, .in_data, .in_ready,
        .pixel_pointer, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
        .busy
    );
    pixel_memory_model pixel_memory_model_inst
    (
        .clk, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata
    );
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic [15:0] p);
        memory_pointer <= p;
        pointer_load <= 1'b1;
        @(posedge clk);
        pointer_load <= 1'b0;
        @(posedge clk);
        chk(pixel_pointer, p);
    endtask
    // Holds the word until the buffer takes it; valid stays up for the next
    task automatic push(input logic [15:0] w);
        in_valid <= 1'b1;
        in_data <= w;
        do
        begin
            @(posedge clk);
            if (in_ready !== 1'b1)
                stalled = 1'b1;
        end
        while (in_ready !== 1'b1);
    endtask
    task automatic settle();
        int i;
        in_valid <= 1'b0;
        i = 0;
        repeat (2) @(posedge clk);
        while (busy !== 1'b0 && i < 64)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 64)
        begin
            n_errors++;
            end_of_test();
        end
    endtask
    function automatic logic [15:0] next_ptr(input logic [15:0] p);
        logic [7:0] c;
        logic [7:0] r;
        logic       edge_col;
        c = p[7:0];
        r = p[15:8];
        edge_col = c == (step_sign ? win_col_last : win_col_first);
        if (!write_direction_select || r == win_row_last)
        begin
            if (!write_direction_select && edge_col)
                r = (r == win_row_last) ? win_row_first : r + 8'h01;
            else if (write_direction_select)
                r = win_row_first;
            if (edge_col)
                c = step_sign ? win_col_first : win_col_last;
            else
                c = step_sign ? c + 8'h01 : c - 8'h01;
        end
        else
            r = r + 8'h01;
        return {r, c};
    endfunction
    function automatic logic [15:0] exp_word(input logic [15:0] st,
        input logic [15:0] h);
        logic [15:0] r;
        logic [15:0] m;
        m = match_value;
        if (bus_width_code == `BUS_W18 || bus_width_code == `BUS_W9)
            return h;
        case (combine_op_code)
            `OP_REPLACE: r = h;
            `OP_OR:      r = st | h;
            `OP_AND:     r = st & h;
            `OP_XOR:     r = st ^ h;
            `OP_STORED_MATCH: r = {st[15:8] == m[15:8] ? h[15:8] : st[15:8],
                                   st[7:0] == m[7:0] ? h[7:0] : st[7:0]};
            `OP_STORED_MISS:  r = {st[15:8] != m[15:8] ? h[15:8] : st[15:8],
                                   st[7:0] != m[7:0] ? h[7:0] : st[7:0]};
            `OP_HOST_MATCH:   r = (h == m) ? h : st;
            default:          r = (h != m) ? h : st;
        endcase
        return (r & ~bit_protect_mask) | (st & bit_protect_mask);
    endfunction
    // Four back-to-back words from the last row, one short of the last column
    task automatic walk();
        logic [15:0] a [4];
        logic [15:0] w [4];
        a[0] = {win_row_last, win_col_last - 8'h01};
        load(a[0]);
        for (int i = 0; i < 4; i++)
        begin
            w[i] = a[0] ^ (16'h0111 * i[15:0]);
            push(w[i]);
            if (i < 3)
                a[i + 1] = next_ptr(a[i]);
        end
        settle();
        for (int i = 0; i < 4; i++)
            chk(pixel_memory_model_inst.mem[a[i]], w[i]);
        chk(pixel_pointer, next_ptr(a[3]));
    endtask
    initial
    begin
        #500000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        logic [15:0] want;
        logic [15:0] got;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 8; k++)
        begin
            {write_direction_select, step_sign} <= k[1:0];
            if (k == 4)
                {win_col_first, win_col_last, win_row_first, win_row_last}
                    <= 32'h0082_00af;
            @(posedge clk);
            walk();
        end
        chk({15'h0000, stalled}, 16'h0001);
        chk({15'h0000, in_ready}, 16'h0001);
        {win_col_first, win_col_last, win_row_first, win_row_last}
            <= 32'h0a0c_1415;
        {write_direction_select, step_sign} <= 2'b01;
        for (int k = 0; k < 128; k++)
        begin
            bus_width_code <= k[6:5];
            combine_op_code <= k[4:2];
            bit_protect_mask <= k[1] ? 16'h0ff0 : 16'h0000;
            pixel_memory_model_inst.mem[16'h140b] = 16'h28a5;
            load(16'h140b);
            push(k[0] ? 16'h5a0f : 16'h2860);
            settle();
            want = exp_word(16'h28a5, in_data);
            got = pixel_memory_model_inst.mem[16'h140b];
            chk(got, want);
        end
        end_of_test();
    end
endmodule
